// File: video_port_pkg.sv
// Shared constants for the camera video port
// Functional notes
// - Frame sync is edge sensitive; only a rising transition starts a frame.
// - Periodic and irregular sync pulses are both accepted.
// - Frame rate follows sync frequency; one frame per accepted edge.
// - Exposure is level controlled by sync or set by a programmed count.
// - Pixel clock runs at 28 MHz and is forwarded to the transmitter.
// - Data and qualifiers are stable for each rising pixel clock edge.
// - Frame valid is high for the whole frame, low outside frames.
// - Line valid is high for the whole line, low between lines.
// - Pixels count only while frame valid and line valid are both high.
// - Data valid is held high in normal operation; receiver ignores it.
// - Integrate enabled output shows when the sensor is integrating.
// - Each pixel clock carries one 12-bit pixel plus three qualifiers.
package video_port_pkg;
	localparam int PIX_W           = 12;
	localparam int FIFO_DEPTH      = 32;
	localparam int CNT_W           = 16;
	localparam int SYS_CLK_MHZ     = 250;
	localparam int PCLK_MHZ        = 28;
	// Two nominal pixel periods with no edge means the clock is gone
	localparam int PCLK_TIMEOUT_CYC =
		2 * ((SYS_CLK_MHZ + PCLK_MHZ - 1) / PCLK_MHZ);
	localparam logic [CNT_W-1:0] LINE_GAP_PCLK   = 16'h0004;
	localparam logic [CNT_W-1:0] FRAME_EDGE_PCLK = 16'h0002;
	localparam logic [PIX_W-1:0] PIX_RESET       = 12'h000;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_EXPOSE,
		ST_FRAME_LEAD,
		ST_LINE,
		ST_LINE_GAP,
		ST_FRAME_TAIL
	} port_state_t;
endpackage

// File: pixel_fifo.sv
// Pixel buffer with registered read data and registered ready
`timescale 1ns/1ps
module pixel_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	// Fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// Drain side, data appears one cycle after a pop
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [CW-1:0]    count_r;
	logic [CW-1:0]    count_nxt;
	logic             push;
	logic             pop;

	// Handshakes on both sides
	assign push      = in_valid_in && in_ready_out;
	assign pop       = out_ready_in && out_valid_out;
	assign count_nxt = count_r + CW'(push) - CW'(pop);

	// Storage has no reset, only pointers, fill level, flags and read data do
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_in;
		end
	end

	// Pointers, fill level and registered flags
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_r      <= '0;
			rd_ptr_r      <= '0;
			count_r       <= '0;
			in_ready_out  <= 1'b0;
			out_valid_out <= 1'b0;
			out_data_out  <= '0;
		end else begin
			if (push) wr_ptr_r <= AW'((32'(wr_ptr_r) + 1) % DEPTH);
			if (pop) begin
				rd_ptr_r     <= AW'((32'(rd_ptr_r) + 1) % DEPTH);
				out_data_out <= mem_r[rd_ptr_r];
			end
			count_r       <= count_nxt;
			in_ready_out  <= (count_nxt != FULL_CNT);
			out_valid_out <= (count_nxt != '0);
		end
	end
endmodule // pixel_fifo

// File: camera_video_port.sv
// Camera side video port: sync input, exposure, frame and line timing
`timescale 1ns/1ps
module camera_video_port
	import video_port_pkg::*;
(
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	// Pins from the frame grabber
	input  wire logic             external_frame_sync_in,
	input  wire logic             pix_clk_in,
	// Configuration levels
	input  wire logic             expo_level_mode_in,
	input  wire logic [CNT_W-1:0] expo_pclk_in,
	input  wire logic [CNT_W-1:0] line_pixels_in,
	input  wire logic [CNT_W-1:0] frame_lines_in,
	// Sensor pixel stream
	input  wire logic             sensor_valid_in,
	output logic                  sensor_ready_out,
	input  wire logic [PIX_W-1:0] sensor_data_in,
	// Link transmitter side
	output logic                  transmitter_clock_input_out,
	output logic      [PIX_W-1:0] pix_data_out,
	output logic                  frame_valid_out,
	output logic                  line_valid_out,
	output logic                  data_valid_out,
	output logic                  integrate_en_out,
	// Status levels
	output logic                  underrun_out,
	output logic                  sync_missed_out,
	output logic                  pclk_lost_out
);
	localparam int TW = $clog2(PCLK_TIMEOUT_CYC + 1);
	localparam logic [TW-1:0] PCLK_TIMEOUT = TW'(PCLK_TIMEOUT_CYC);

	port_state_t      state_r;
	port_state_t      state_nxt;
	logic [2:0]       sync_sh_r;
	logic [2:0]       pclk_sh_r;
	logic             sync_lvl_r;
	logic             pclk_lvl_r;
	logic             sync_pend_r;
	logic             tick_d_r;
	logic             pclk_lvl_d_r;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [CNT_W-1:0] line_r;
	logic [CNT_W-1:0] line_nxt;
	logic [TW-1:0]    pclk_wd_r;
	logic             sync_agree;
	logic             pclk_agree;
	logic             sync_rise;
	logic             pclk_rise;
	logic             pclk_fall;
	logic             fifo_valid;
	logic             fifo_pop;
	logic [PIX_W-1:0] fifo_data;
	logic             in_line;
	logic             in_frame;
	logic             cnt_done;
	logic             last_line;
	logic             line_next;

	// Pin filtering: a change counts once the last two stages agree
	assign sync_agree = (sync_sh_r[1] == sync_sh_r[2]);
	assign pclk_agree = (pclk_sh_r[1] == pclk_sh_r[2]);
	assign sync_rise  = sync_agree && sync_sh_r[2] && !sync_lvl_r;
	assign pclk_rise  = pclk_agree && pclk_sh_r[2] && !pclk_lvl_r;
	assign pclk_fall  = pclk_agree && !pclk_sh_r[2] && pclk_lvl_r;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync_sh_r  <= 3'h0;
			pclk_sh_r  <= 3'h0;
			sync_lvl_r <= 1'b0;
			pclk_lvl_r <= 1'b0;
		end else begin
			sync_sh_r <= {sync_sh_r[1:0], external_frame_sync_in};
			pclk_sh_r <= {pclk_sh_r[1:0], pix_clk_in};
			if (sync_agree) sync_lvl_r <= sync_sh_r[2];
			if (pclk_agree) pclk_lvl_r <= pclk_sh_r[2];
		end
	end

	// Pixel clock watchdog, since the grabber may stop its oscillator
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pclk_wd_r     <= '0;
			pclk_lost_out <= 1'b0;
		end else begin
			if (pclk_rise || pclk_fall) begin
				pclk_wd_r <= '0;
			end else if (pclk_wd_r != PCLK_TIMEOUT) begin
				pclk_wd_r <= pclk_wd_r + TW'(1);
			end
			pclk_lost_out <= (pclk_wd_r == PCLK_TIMEOUT);
		end
	end

	// Sync edge held until the pixel-clock sequencer takes it; an edge
	// landing in the take cycle is used there, so it never starts twice,
	// and an edge during readout is never queued for later
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync_pend_r     <= 1'b0;
			sync_missed_out <= 1'b0;
		end else begin
			if (sync_rise && state_r == ST_IDLE && !pclk_rise) begin
				sync_pend_r <= 1'b1;
			end else if (pclk_rise && state_r == ST_IDLE) begin
				sync_pend_r <= 1'b0;
			end
			// Edge during readout cannot start a frame: flag it
			if (sync_rise && state_r != ST_IDLE) begin
				sync_missed_out <= 1'b1;
			end else if (sync_rise) begin
				sync_missed_out <= 1'b0;
			end
		end
	end

	// Sequencer decode, advanced once per pixel clock rise
	assign cnt_done  = (cnt_r == '0);
	assign last_line = (line_r == '0);
	assign in_line   = (state_r == ST_LINE);
	assign in_frame  = (state_r != ST_IDLE) && (state_r != ST_EXPOSE);
	// Pop on the rise that enters or stays in a line, so the word is
	// already registered when the outputs load one cycle later
	assign line_next = (state_nxt == ST_LINE);
	assign fifo_pop  = pclk_rise && line_next && fifo_valid;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = (cnt_r == '0) ? cnt_r : cnt_r - 16'h0001;
		line_nxt  = line_r;
		case (state_r)
			ST_IDLE: begin
				// One frame per accepted edge sets the frame rate
				if (sync_pend_r || sync_rise) begin
					state_nxt = ST_EXPOSE;
					cnt_nxt   = expo_pclk_in;
				end
			end
			ST_EXPOSE: begin
				// Level mode ends on sync low, else on the count
				if (expo_level_mode_in ? !sync_lvl_r : cnt_done) begin
					state_nxt = ST_FRAME_LEAD;
					cnt_nxt   = FRAME_EDGE_PCLK;
				end
			end
			ST_FRAME_LEAD: begin
				if (cnt_done) begin
					state_nxt = ST_LINE;
					cnt_nxt   = line_pixels_in - 16'h0001;
					line_nxt  = frame_lines_in - 16'h0001;
				end
			end
			ST_LINE: begin
				if (cnt_done) begin
					state_nxt = last_line ? ST_FRAME_TAIL : ST_LINE_GAP;
					cnt_nxt   = last_line ? FRAME_EDGE_PCLK : LINE_GAP_PCLK;
				end
			end
			ST_LINE_GAP: begin
				if (cnt_done) begin
					state_nxt = ST_LINE;
					cnt_nxt   = line_pixels_in - 16'h0001;
					line_nxt  = line_r - 16'h0001;
				end
			end
			ST_FRAME_TAIL: begin
				if (cnt_done) state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r  <= ST_IDLE;
			cnt_r    <= '0;
			line_r   <= '0;
			tick_d_r <= 1'b0;
		end else begin
			tick_d_r <= pclk_rise;
			if (pclk_rise) begin
				state_r <= state_nxt;
				cnt_r   <= cnt_nxt;
				line_r  <= line_nxt;
			end
		end
	end

	// Outputs load one cycle after the rise so the popped word is ready;
	// the forwarded clock rises a cycle later still, giving setup time
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pix_data_out     <= PIX_RESET;
			frame_valid_out  <= 1'b0;
			line_valid_out   <= 1'b0;
			data_valid_out   <= 1'b0;
			integrate_en_out <= 1'b0;
			underrun_out     <= 1'b0;
			pclk_lvl_d_r     <= 1'b0;
			transmitter_clock_input_out <= 1'b0;
		end else begin
			pclk_lvl_d_r <= pclk_lvl_r;
			transmitter_clock_input_out <= pclk_lvl_d_r;
			data_valid_out <= 1'b1;
			if (tick_d_r) begin
				// All qualifiers update together with the pixel
				frame_valid_out  <= in_frame;
				line_valid_out   <= in_line;
				integrate_en_out <= (state_r == ST_EXPOSE);
				// One pixel per clock; zero when the sensor lags
				pix_data_out <= (in_line && !underrun_out) ?
					fifo_data : PIX_RESET;
			end
			if (pclk_rise && state_r == ST_IDLE) begin
				underrun_out <= 1'b0;
			end else if (pclk_rise && line_next && !fifo_valid) begin
				underrun_out <= 1'b1;
			end
		end
	end

	// Sensor words wait here until the line reaches them
	pixel_fifo #(
		.WIDTH (PIX_W),
		.DEPTH (FIFO_DEPTH)
	) i_pixel_fifo (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n_in),
		.in_valid_in   (sensor_valid_in),
		.in_ready_out  (sensor_ready_out),
		.in_data_in    (sensor_data_in),
		.out_valid_out (fifo_valid),
		.out_ready_in  (fifo_pop),
		.out_data_out  (fifo_data)
	);
endmodule // camera_video_port

// File: camera_video_port_monitor.sv
// Concurrent checks on the camera video port pins
`timescale 1ns/1ps
module camera_video_port_monitor (
	// Clock, reset and pins in
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic external_frame_sync_in,
	input wire logic pix_clk_in,
	// Link outputs
	input wire logic transmitter_clock_input_out,
	input wire logic frame_valid_out,
	input wire logic line_valid_out,
	input wire logic data_valid_out,
	input wire logic integrate_en_out,
	input wire logic sync_missed_out
);
	logic [7:0] age_r;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// Age of the last sync rise; saturates so it never wraps
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) age_r <= 8'hFF;
		else if ($rose(external_frame_sync_in)) age_r <= 8'h00;
		else if (age_r != 8'hFF) age_r <= age_r + 8'h01;
	end
	// Qualifier, exposure and clock timing
	property p_dval; $past(rst_n_in) |-> data_valid_out; endproperty
	a_dval: assert property (p_dval) else $error("dval low");
	property p_lvfv; line_valid_out |-> frame_valid_out; endproperty
	a_lvfv: assert property (p_lvfv) else $error("lval alone");
	property p_lead;
		$rose(frame_valid_out) |-> (frame_valid_out && !line_valid_out)[*8];
	endproperty
	a_lead: assert property (p_lead) else $error("no lead");
	property p_start;
		$rose(external_frame_sync_in) && !frame_valid_out && !integrate_en_out
			|-> ##[1:30] integrate_en_out;
	endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_cause; $rose(integrate_en_out) |-> age_r < 8'h1E; endproperty
	a_cause: assert property (p_cause) else $error("no cause");
	property p_expo;
		$fell(integrate_en_out) |-> ##[0:12] frame_valid_out;
	endproperty
	a_expo: assert property (p_expo) else $error("no frame");
	property p_miss;
		$rose(external_frame_sync_in) && frame_valid_out
			|-> ##[1:8] sync_missed_out;
	endproperty
	a_miss: assert property (p_miss) else $error("no flag");
	property p_fwd;
		$rose(pix_clk_in) |-> ##[2:8] $rose(transmitter_clock_input_out);
	endproperty
	a_fwd: assert property (p_fwd) else $error("no clock");
	property p_align;
		$changed(line_valid_out) |=> $rose(transmitter_clock_input_out);
	endproperty
	a_align: assert property (p_align) else $error("skew");
endmodule // camera_video_port_monitor
bind camera_video_port camera_video_port_monitor
	i_camera_video_port_monitor (.*);

// File: grabber_model.sv
// Frame grabber model: sync source and rising edge capture
`timescale 1ns/1ps
module grabber_model
	import video_port_pkg::*;
(
	// Link side
	input  wire logic             clk_in,
	input  wire logic             tclk_in,
	input  wire logic [PIX_W-1:0] data_in,
	input  wire logic             fval_in,
	input  wire logic             lval_in,
	input  wire logic             integ_in,
	// Sync pin
	output logic                  sync_out = 1'b0
);
	logic [PIX_W-1:0] pix_q[$];
	logic             lval_d = 1'b0;
	int               lines;
	int               integ_n;
	// Words outside fval and lval are dropped
	always @(posedge tclk_in) begin
		if (fval_in && lval_in) pix_q.push_back(data_in);
		if (lval_in && !lval_d) lines++;
		if (integ_in) integ_n++;
		lval_d = lval_in;
	end
	task automatic clear();
		pix_q.delete();
		lines = 0;
		integ_n = 0;
	endtask
	// One pulse per wanted frame; caller sets the high time
	task automatic send_sync(input int hi);
		@(posedge clk_in);
		sync_out <= 1'b1;
		repeat (hi) @(posedge clk_in);
		sync_out <= 1'b0;
	endtask
endmodule // grabber_model

// File: camera_video_port_tb.sv
// Self-checking bench for the camera video port
`timescale 1ns/1ps
module camera_video_port_tb;
	import video_port_pkg::*;
	logic             clk_in, rst_n_in, pclk, sync, lvl, s_vld, s_rdy;
	logic             tclk, fval, lval, dval, integ, under, miss;
	logic             lost, pclk_run;
	logic [CNT_W-1:0] expo, px, ln;
	logic [PIX_W-1:0] s_data, pix, rd_word;
	int               err_count, n_compared;
	// System clock, and a pixel clock of unrelated phase
	initial begin
		clk_in = 1'b0;
		pclk = 1'b0;
		pclk_run = 1'b1;
		fork
			forever #2 clk_in = ~clk_in;
			#1.3 forever #16 if (pclk_run) pclk = ~pclk;
		join
	end
	camera_video_port i_camera_video_port (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .external_frame_sync_in(sync), .pix_clk_in(pclk),
		.expo_level_mode_in(lvl), .expo_pclk_in(expo), .line_pixels_in(px),
		.frame_lines_in(ln), .sensor_valid_in(s_vld), .sensor_ready_out(s_rdy),
		.sensor_data_in(s_data), .transmitter_clock_input_out(tclk),
		.pix_data_out(pix), .frame_valid_out(fval), .line_valid_out(lval),
		.data_valid_out(dval), .integrate_en_out(integ), .underrun_out(under),
		.sync_missed_out(miss), .pclk_lost_out(lost));
	grabber_model i_grabber_model (.clk_in(clk_in), .tclk_in(tclk),
		.data_in(pix), .fval_in(fval), .lval_in(lval), .integ_in(integ),
		.sync_out(sync));
	task automatic chk(input string nm, input logic [15:0] e, g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic report_and_stop();
		if (err_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wait_fv(input logic v);
		int n;
		n = 0;
		while (fval !== v && n < 4000) begin
			@(negedge clk_in);
			n++;
		end
		chk("fval", v, fval);
	endtask
	// Fill the buffer until ready drops
	task automatic run_fill();
		int n;
		logic acc;
		n = 0;
		acc = 1'b1;
		@(posedge clk_in);
		while (acc && n < 40) begin
			s_vld <= 1'b1;
			s_data <= n[PIX_W-1:0];
			@(negedge clk_in);
			acc = s_rdy;
			@(posedge clk_in);
			if (acc) n++;
		end
		s_vld <= 1'b0;
		chk("fill", FIFO_DEPTH, n);
	endtask
	// One exposure and frame; words past av are underrun zeros
	task automatic run_frame(input logic m, input logic [15:0] e, p, l,
		input int hi, av);
		int i;
		logic [PIX_W-1:0] w;
		@(posedge clk_in);
		{lvl, expo, px, ln} <= {m, e, p, l};
		i_grabber_model.clear();
		i_grabber_model.send_sync(hi);
		wait_fv(1'b1);
		wait_fv(1'b0);
		chk("pixels", p * l, i_grabber_model.pix_q.size());
		chk("lines", l, i_grabber_model.lines);
		if (!m) chk("expo", e + 16'h0001, i_grabber_model.integ_n);
		for (i = 0; i < p * l; i++) begin
			w = (i < av) ? rd_word : 12'h000;
			chk("pixel", w, i_grabber_model.pix_q[i]);
			if (i < av) rd_word++;
		end
		chk("dval", 1'b1, dval);
	endtask
	// A sync edge during readout is dropped and flagged
	task automatic run_missed();
		fork
			run_frame(1'b0, 16'h0001, 16'h0003, 16'h0001, 8, 99);
			begin
				@(posedge fval);
				i_grabber_model.send_sync(8);
			end
		join
		chk("missed", 1'b1, miss);
		repeat (400) @(negedge clk_in);
		chk("rearm", 1'b0, fval | integ);
	endtask
	// Stopped pixel clock raises the lost flag, restarting clears it
	task automatic run_lost();
		@(posedge clk_in);
		pclk_run <= 1'b0;
		repeat (40) @(negedge clk_in);
		chk("lost", 1'b1, lost);
		@(posedge clk_in);
		pclk_run <= 1'b1;
		repeat (40) @(negedge clk_in);
		chk("lost", 1'b0, lost);
	endtask
	// Main sequence
	initial begin
		{rst_n_in, s_vld, lvl, s_data, expo, rd_word, px, ln} = '0;
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (8) @(negedge clk_in);
		chk("dval", 1'b1, dval);
		chk("lost", 1'b0, lost);
		run_fill();
		run_frame(1'b0, 16'h0003, 16'h0004, 16'h0002, 8, 99);
		run_frame(1'b1, 16'h0000, 16'h0005, 16'h0003, 80, 99);
		run_missed();
		run_frame(1'b0, 16'h0000, 16'h0004, 16'h0002, 8, 6);
		chk("underrun", 1'b1, under);
		chk("missed", 1'b0, miss);
		run_lost();
		report_and_stop();
	end
	// Watchdog, far past the roughly 1330 cycles needed
	initial begin
		repeat (60000) @(posedge clk_in);
		err_count++;
		report_and_stop();
	end
endmodule // camera_video_port_tb
